// File: design/arf_pkg.sv
// Constants and types for the converter result formatting block
package arf_pkg;
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL_B = 8'h03;
   localparam logic [7:0] ADDR_RES_LOW = 8'h04;
   localparam logic [7:0] ADDR_RES_HIGH = 8'h05;
   localparam logic [7:0] ADDR_CTRL_A = 8'h06;
   localparam logic [7:0] ADDR_CHAN_REF = 8'h07;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CHREF_REFS1 = 7;
   localparam int CHREF_REFS0 = 6;
   localparam int CHREF_LEFT_ALIGN = 5;
   localparam int CHREF_REFS2 = 4;
   localparam int CTRLA_ENABLE = 7;
   localparam int CTRLA_DONE = 4;
   localparam int CTRLB_BIPOLAR = 7;
   localparam int CTRLB_POL_REV = 5;

   // ****************************************************************
   // Reset values and codes
   // ****************************************************************
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [9:0] RST_RESULT = 10'h000;
   localparam logic [3:0] CHAN_TEMP = 4'hf;
   localparam logic [3:0] CHAN_DIFF_LO = 4'h4;
   localparam logic [3:0] CHAN_DIFF_HI = 4'hb;
   localparam logic [9:0] CODE_ZERO = 10'h000;
   localparam logic [9:0] CODE_FULL = 10'h3ff;
   localparam logic signed [16:0] UNI_MAX = 17'sh003ff;
   localparam logic signed [16:0] BIP_MAX = 17'sh001ff;
   localparam logic signed [16:0] BIP_MIN = -17'sh00200;
   localparam logic signed [16:0] GAIN_HIGH = 17'sh00014;
   localparam logic [5:0] LEFT_PAD = 6'h00;
   localparam logic [5:0] HIGH_PAD = 6'h00;

   // ****************************************************************
   // Conversion types
   // ****************************************************************
   typedef enum logic [1:0] {
      ARF_SINGLE = 2'b00,
      ARF_UNIPOLAR = 2'b01,
      ARF_BIPOLAR = 2'b10
   } arf_conv_t;
endpackage

// File: design/arf_top.sv
// Result formatting, mode selection and registers of the 10-bit converter
// Operation
// - Span ground to reference maps to equal steps, zero lowest, all ones highest.
// - Finished code readable in the result byte pair once done flag is set.
// - Single-ended code equals input times 1024 over reference.
// - Single-ended 0x000 is ground, 0x3FF is reference minus one step, unsigned.
// - Unipolar difference times 1024 over reference, times gain 1 or 20.
// - Unipolar result forced to zero when negative input exceeds positive.
// - Unipolar results are unsigned codes 0x000 through 0x3FF.
// - Differential is unipolar by default, bipolar when bipolar_select is one.
// - Bipolar allows negative above positive, difference times 512 times gain.
// - Bipolar results are two's complement from 0x200 through 0x1FF.
// - Top result bit in high byte gives sign, one negative.
// - Polarity reverse swaps unipolar differential inputs to keep full range.
// - Channel select 1111 routes the temperature sensor and enables it.
// - Left align sets justification of the pair, effective immediately.
`timescale 1ns/1ps
`default_nettype none
module arf_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic conv_valid,
   input wire logic [9:0] samp_pos,
   input wire logic [9:0] samp_neg,
   output logic conv_enable,
   output logic [3:0] chan_route,
   output logic [2:0] ref_select,
   output logic gain_high,
   output logic temp_sensor_en
);
   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0] chan_ref;
   logic [7:0] ctrl_a;
   logic [7:0] ctrl_b;
   logic [9:0] result_code;
   logic conversion_done_flag;
   logic [3:0] channel_select;
   logic left_align_result;
   logic bipolar_select;
   logic polarity_reverse;
   logic result_sign_bit;
   logic [7:0] result_low_byte;
   logic [7:0] result_high_byte;
   logic [7:0] next_rdata;
   logic [9:0] next_result;
   arf_pkg::arf_conv_t conv_type;
   logic signed [16:0] diff;
   logic signed [16:0] amp;
   logic signed [16:0] half;

   assign channel_select = chan_ref[3:0];
   assign left_align_result = chan_ref[arf_pkg::CHREF_LEFT_ALIGN];
   assign bipolar_select = ctrl_b[arf_pkg::CTRLB_BIPOLAR];
   assign polarity_reverse = ctrl_b[arf_pkg::CTRLB_POL_REV];
   // sign is the top code bit
   assign result_sign_bit = result_code[9];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chan_ref <= arf_pkg::RST_REG;
      end else if (wr && addr == arf_pkg::ADDR_CHAN_REF) begin
         chan_ref <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_b <= arf_pkg::RST_REG;
      end else if (wr && addr == arf_pkg::ADDR_CTRL_B) begin
         ctrl_b <= wdata;
      end
   end

   // Done flag lives apart from the writable bits; set beats a clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_a <= arf_pkg::RST_REG;
      end else if (wr && addr == arf_pkg::ADDR_CTRL_A) begin
         ctrl_a <= wdata;
         ctrl_a[arf_pkg::CTRLA_DONE] <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         conversion_done_flag <= 1'b0;
      end else if (conv_valid && conv_enable) begin
         conversion_done_flag <= 1'b1;
      end else if (wr && addr == arf_pkg::ADDR_CTRL_A && wdata[arf_pkg::CTRLA_DONE]) begin
         conversion_done_flag <= 1'b0;
      end
   end

   // ****************************************************************
   // Analog front end controls
   // ****************************************************************
   // input routing, reference, gain, sensor and enable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chan_route <= 4'h0;
         ref_select <= 3'h0;
         gain_high <= 1'b0;
         temp_sensor_en <= 1'b0;
         conv_enable <= 1'b0;
      end else begin
         if (wr && addr == arf_pkg::ADDR_CHAN_REF) begin
            chan_route <= wdata[3:0];
            ref_select <= {wdata[arf_pkg::CHREF_REFS2], wdata[arf_pkg::CHREF_REFS1],
                           wdata[arf_pkg::CHREF_REFS0]};
            gain_high <= wdata[0];
            temp_sensor_en <= (wdata[3:0] == arf_pkg::CHAN_TEMP);
         end
         if (wr && addr == arf_pkg::ADDR_CTRL_A) begin
            conv_enable <= wdata[arf_pkg::CTRLA_ENABLE];
         end
      end
   end

   // ****************************************************************
   // Result coding
   // ****************************************************************
   // mode selection
   always_comb begin
      if (channel_select >= arf_pkg::CHAN_DIFF_LO && channel_select <= arf_pkg::CHAN_DIFF_HI) begin
         conv_type = bipolar_select ? arf_pkg::ARF_BIPOLAR : arf_pkg::ARF_UNIPOLAR;
      end else begin
         conv_type = arf_pkg::ARF_SINGLE;
      end
   end

   // Samples are in steps of reference/1024, so the scaling is implicit
   always_comb begin
      diff = $signed({7'h00, samp_pos}) - $signed({7'h00, samp_neg});
      if (polarity_reverse && conv_type == arf_pkg::ARF_UNIPOLAR) begin
         diff = -diff;
      end
      amp = gain_high ? 17'(diff * arf_pkg::GAIN_HIGH) : diff;
      half = amp >>> 1;
      case (conv_type)
         arf_pkg::ARF_SINGLE: begin
            next_result = samp_pos;
         end
         arf_pkg::ARF_UNIPOLAR: begin
            if (amp < 0) begin
               next_result = arf_pkg::CODE_ZERO;
            end else if (amp > arf_pkg::UNI_MAX) begin
               next_result = arf_pkg::CODE_FULL;
            end else begin
               next_result = amp[9:0];
            end
         end
         arf_pkg::ARF_BIPOLAR: begin
            if (half > arf_pkg::BIP_MAX) begin
               next_result = arf_pkg::BIP_MAX[9:0];
            end else if (half < arf_pkg::BIP_MIN) begin
               next_result = arf_pkg::BIP_MIN[9:0];
            end else begin
               next_result = half[9:0];
            end
         end
         default: begin
            next_result = arf_pkg::CODE_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         result_code <= arf_pkg::RST_RESULT;
      end else if (conv_valid && conv_enable) begin
         result_code <= next_result;
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   // justification follows the live bit, not the capture time
   always_comb begin
      if (left_align_result) begin
         result_low_byte = {result_code[1:0], arf_pkg::LEFT_PAD};
         result_high_byte = result_code[9:2];
      end else begin
         result_low_byte = result_code[7:0];
         result_high_byte = {arf_pkg::HIGH_PAD, result_sign_bit, result_code[8]};
      end
   end

   always_comb begin
      case (addr)
         arf_pkg::ADDR_CTRL_B: next_rdata = ctrl_b;
         arf_pkg::ADDR_RES_LOW: next_rdata = result_low_byte;
         arf_pkg::ADDR_RES_HIGH: next_rdata = result_high_byte;
         arf_pkg::ADDR_CHAN_REF: next_rdata = chan_ref;
         arf_pkg::ADDR_CTRL_A: begin
            next_rdata = ctrl_a;
            next_rdata[arf_pkg::CTRLA_DONE] = conversion_done_flag;
         end
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 8'h00;
      end else if (rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= 8'h00;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   logic take;
   assign take = conv_valid && conv_enable;

   property p_zero_code;
      @(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_SINGLE && samp_pos == 10'h000 |=> result_code == 10'h000;
   endproperty
   a_zero_code: assert property (p_zero_code) else $error("Ground not coded zero");

   property p_done;
      @(posedge clk) disable iff (!rst_b)
      take |=> conversion_done_flag;
   endproperty
   a_done: assert property (p_done) else $error("Done flag not set");

   property p_rd_idle;
      @(posedge clk) disable iff (!rst_b)
      !rd |=> rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("Read data not idle");

   property p_full_code;
      @(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_SINGLE && samp_pos == 10'h3ff |=> result_code == 10'h3ff;
   endproperty
   a_full_code: assert property (p_full_code) else $error("Full scale not all ones");

   property p_single;
      @(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_SINGLE |=> result_code == $past(samp_pos);
   endproperty
   a_single: assert property (p_single) else $error("Single ended code wrong");

   property p_uni_sat;
      @(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_UNIPOLAR && !polarity_reverse && samp_neg > samp_pos
      |=> result_code == 10'h000;
   endproperty
   a_uni_sat: assert property (p_uni_sat) else $error("Unipolar not saturated");

   property p_uni_gain1;
      @(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_UNIPOLAR && !polarity_reverse && !gain_high
      && samp_pos >= samp_neg |=> result_code == $past(samp_pos) - $past(samp_neg);
   endproperty
   a_uni_gain1: assert property (p_uni_gain1) else $error("Unipolar code wrong");

   // Widened sums so a large negative sample cannot wrap past the threshold
   property p_uni_top;
      @(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_UNIPOLAR && !polarity_reverse && gain_high
      && {1'b0, samp_pos} >= {1'b0, samp_neg} + 11'h034 |=> result_code == 10'h3ff;
   endproperty
   a_uni_top: assert property (p_uni_top) else $error("Unipolar not clipped");

   property p_bip_half;
      @(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_BIPOLAR && !gain_high
      |=> result_code == 10'(($signed({1'b0, $past(samp_pos)}) - $signed({1'b0, $past(samp_neg)})) >>> 1);
   endproperty
   a_bip_half: assert property (p_bip_half) else $error("Bipolar code wrong");

   property p_bip_clamp;
      @(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_BIPOLAR && gain_high
      && {1'b0, samp_pos} >= {1'b0, samp_neg} + 11'h034 |=> result_code == 10'h1ff;
   endproperty
   a_bip_clamp: assert property (p_bip_clamp) else $error("Bipolar clamp wrong");

   property p_sign;
      @(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_BIPOLAR && {1'b0, samp_neg} > {1'b0, samp_pos} + 11'h001
      |=> result_sign_bit && (left_align_result ? result_high_byte[7] : result_high_byte[1]);
   endproperty
   a_sign: assert property (p_sign) else $error("Sign bit wrong");

   property p_swap;
      @(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_UNIPOLAR && polarity_reverse && !gain_high
      && samp_neg >= samp_pos |=> result_code == $past(samp_neg) - $past(samp_pos);
   endproperty
   a_swap: assert property (p_swap) else $error("Polarity reverse wrong");

   property p_temp;
      @(posedge clk) disable iff (!rst_b)
      wr && addr == arf_pkg::ADDR_CHAN_REF && wdata[3:0] == 4'hf |=> temp_sensor_en;
   endproperty
   a_temp: assert property (p_temp) else $error("Sensor not enabled");

   property p_right;
      @(posedge clk) disable iff (!rst_b)
      rd && addr == arf_pkg::ADDR_RES_HIGH && !left_align_result
      |=> rdata == {6'h00, $past(result_code[9:8])};
   endproperty
   a_right: assert property (p_right) else $error("Right justify wrong");

   property p_left;
      @(posedge clk) disable iff (!rst_b)
      rd && addr == arf_pkg::ADDR_RES_LOW && left_align_result
      |=> rdata == {$past(result_code[1:0]), 6'h00};
   endproperty
   a_left: assert property (p_left) else $error("Left justify wrong");

   c_bipolar: cover property (@(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_BIPOLAR);
   c_uni_gain: cover property (@(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_UNIPOLAR && gain_high);
   c_uni_swap: cover property (@(posedge clk) disable iff (!rst_b)
      take && conv_type == arf_pkg::ARF_UNIPOLAR && polarity_reverse);
   c_temp_read: cover property (@(posedge clk) disable iff (!rst_b)
      temp_sensor_en && take ##[1:20] rd && addr == arf_pkg::ADDR_RES_HIGH);
endmodule
`default_nettype wire

// File: testbench/arf_input_model.sv
// Behavioural model of the analog inputs and the temperature sensor
`timescale 1ns/1ps
`default_nettype none
module arf_input_model #(
   parameter logic [9:0] TEMP_CODE = 10'h12c
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic go,
   input wire logic [9:0] pos,
   input wire logic [9:0] neg,
   input wire logic [3:0] dly,
   input wire logic temp_en,
   output logic conv_valid,
   output logic [9:0] samp_pos,
   output logic [9:0] samp_neg
);
   // ****************************************************************
   // Sample delivery
   // ****************************************************************
   logic busy;
   logic [3:0] cnt;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy <= 1'h0;
         cnt <= 4'h0;
         conv_valid <= 1'h0;
         samp_pos <= 10'h000;
         samp_neg <= 10'h000;
      end else if (busy && cnt == 4'h0) begin
         busy <= 1'h0;
         conv_valid <= 1'h1;
         samp_pos <= temp_en ? TEMP_CODE : pos;
         samp_neg <= neg;
      end else begin
         busy <= busy | go;
         cnt <= go ? dly : cnt - 4'h1;
         conv_valid <= 1'h0;
         // Samples toggle outside the valid cycle so stale data cannot pass
         samp_pos <= ~samp_pos;
         samp_neg <= ~samp_neg;
      end
   end
endmodule
`default_nettype wire

// File: testbench/arf_top_tb_top.sv
// Self-checking bench for the converter result formatting block
`timescale 1ns/1ps
`default_nettype none
module arf_top_tb_top;
   localparam logic [9:0] TEMP = 10'h12c;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic go = 1'h0;
   logic [9:0] ppos = 10'h000;
   logic [9:0] pneg = 10'h000;
   logic [3:0] dly = 4'h0;
   logic [7:0] rdata;
   logic conv_valid, conv_enable, gain_high, temp_sensor_en;
   logic [9:0] samp_pos, samp_neg;
   logic [3:0] chan_route;
   logic [2:0] ref_select;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   always #12.5 clk = ~clk;
   arf_top u_dut (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .conv_valid, .samp_pos,
      .samp_neg, .conv_enable, .chan_route, .ref_select, .gain_high, .temp_sensor_en);
   arf_input_model #(.TEMP_CODE(TEMP)) u_inputs (.clk, .rst_b, .go, .pos(ppos), .neg(pneg),
      .dly, .temp_en(temp_sensor_en), .conv_valid, .samp_pos, .samp_neg);
   // ****************************************************************
   // Tasks and model
   // ****************************************************************
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 d = rdata;
   endtask
   task automatic conv(input logic [9:0] p, input logic [9:0] n);
      @(posedge clk);
      go <= 1'h1;
      ppos <= p;
      pneg <= n;
      dly <= 4'($urandom_range(9, 0));
      @(posedge clk);
      go <= 1'h0;
      for (int i = 0; i < 20; i++) begin
         #1;
         if (conv_valid === 1'h1) break;
         @(posedge clk);
      end
   endtask
   // Saturation and halving follow the coding of each conversion type
   function automatic int expv(input logic [7:0] cr, input logic [7:0] cb, input int p,
      input int n);
      int d;
      if (cr[3:0] < 4'h4 || cr[3:0] > 4'hb) return p;
      d = (cb[7] == 1'h0 && cb[5] == 1'h1) ? n - p : p - n;
      if (cr[0]) d = d * 20;
      if (cb[7]) begin
         d = d >>> 1;
         return (d > 511) ? 511 : (d < -512) ? -512 : d;
      end
      return (d > 1023) ? 1023 : (d < 0) ? 0 : d;
   endfunction
   task automatic chk_pair(input logic left, input logic [9:0] e, output logic [7:0] hi);
      logic [7:0] lo;
      rd_reg(arf_pkg::ADDR_RES_LOW, lo);
      rd_reg(arf_pkg::ADDR_RES_HIGH, hi);
      chk({hi, lo}, left ? {e, 6'h00} : {6'h00, e});
   endtask
   task automatic run(input logic [7:0] cr, input logic [7:0] cb, input logic [9:0] p,
      input logic [9:0] n);
      int e;
      logic [7:0] hi;
      wr_reg(arf_pkg::ADDR_CHAN_REF, cr);
      wr_reg(arf_pkg::ADDR_CTRL_B, cb);
      #1 chk({chan_route, ref_select, temp_sensor_en},
         {cr[3:0], cr[4], cr[7:6], cr[3:0] == 4'hf});
      if (cr[3:0] > 4'h3 && cr[3:0] < 4'hc) chk(gain_high, cr[0]);
      conv(p, n);
      e = expv(cr, cb, p, n);
      rd_reg(arf_pkg::ADDR_CTRL_A, hi);
      chk(hi[arf_pkg::CTRLA_DONE], 1'h1);
      chk_pair(cr[5], 10'(e), hi);
      if (cb[7] && cr[3:0] > 4'h3 && cr[3:0] < 4'hc) chk(cr[5] ? hi[7] : hi[1], e < 0);
      wr_reg(arf_pkg::ADDR_CHAN_REF, cr ^ 8'h20);
      chk_pair(!cr[5], 10'(e), hi);
      wr_reg(arf_pkg::ADDR_CTRL_A, 8'h90);
   endtask
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      logic [7:0] v;
      logic [7:0] cr;
      logic [9:0] p;
      void'($urandom(36969));
      repeat (12) @(posedge clk);
      rst_b <= 1'h1;
      for (int a = 3; a < 9; a++) begin
         rd_reg(a == 8 ? 8'h10 : 8'(a), v);
         chk(v, 8'h00);
      end
      wr_reg(8'h10, 8'hff);
      rd_reg(8'h10, v);
      chk(v, 8'h00);
      wr_reg(arf_pkg::ADDR_CTRL_A, 8'h80);
      rd_reg(arf_pkg::ADDR_CTRL_A, v);
      chk({v, conv_enable}, {8'h80, 1'h1});
      @(posedge clk);
      #1 chk(rdata, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 12; i++) begin
         p = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom);
         run(8'(($urandom & 32'h20) | (i % 4)), 8'($urandom), p, 10'($urandom));
      end
      $display("test single-ended done");
      run(8'h06, 8'h00, 10'h3ff, 10'h000);
      run(8'h06, 8'h00, 10'h000, 10'h3ff);
      run(8'h07, 8'h00, 10'h3ff, 10'h000);
      run(8'h0a, 8'h80, 10'h3ff, 10'h000);
      run(8'h0a, 8'h80, 10'h000, 10'h3ff);
      run(8'h0b, 8'h80, 10'h3ff, 10'h000);
      for (int i = 0; i < 48; i++) begin
         p = 10'($urandom);
         cr = 8'(($urandom & 32'h20) | (4 + i % 8));
         run(cr, 8'(($urandom & 32'h7f) | ((i / 24) << 7)),
            p, p ^ 10'($urandom_range(31, 0)));
      end
      $display("test differential done");
      run(8'h8f, 8'h00, TEMP, 10'h000);
      wr_reg(arf_pkg::ADDR_CHAN_REF, 8'h8f);
      rd_reg(arf_pkg::ADDR_RES_LOW, v);
      rd_reg(arf_pkg::ADDR_RES_HIGH, cr);
      chk(({8'h00, cr} << 8) | {8'h00, v}, {6'h00, TEMP});
      $display("test temperature done");
      wr_reg(arf_pkg::ADDR_CTRL_A, 8'h00);
      // Leave the sensor channel so an ignored sample would differ from the held code
      wr_reg(arf_pkg::ADDR_CHAN_REF, 8'h00);
      conv(10'h155, 10'h0aa);
      rd_reg(arf_pkg::ADDR_CTRL_A, v);
      chk(v, 8'h00);
      chk_pair(1'h0, TEMP, v);
      $display("test disabled done");
      give_verdict();
   end
endmodule
`default_nettype wire
